// >>> design/ssc_pkg.sv
// Package for the sequence select controller: register map and constants
package ssc_pkg;
   // Register word addresses (plain port, word index)
   localparam logic [3:0] SSC_A_CTRL     = 4'h0;
   localparam logic [3:0] SSC_A_LENGTH   = 4'h1;
   localparam logic [3:0] SSC_A_SELECT   = 4'h2;
   localparam logic [3:0] SSC_A_COUPLE   = 4'h3;
   localparam logic [3:0] SSC_A_STATUS   = 4'h4;
   localparam logic [3:0] SSC_A_BLOCK    = 4'h5;
   localparam logic [3:0] SSC_A_STEPWR   = 4'h6;
   localparam logic [3:0] SSC_A_PLAY     = 4'h7;
   // Control register field positions
   localparam int SSC_CTRL_SRC_EXT  = 0;
   localparam int SSC_CTRL_IMMED    = 1;
   localparam int SSC_CTRL_LEADIN   = 2;
   localparam int SSC_CTRL_COUPLED  = 3;
   localparam int SSC_CTRL_ARMED    = 4;
   localparam int SSC_CTRL_ARM_BUS  = 5;
   localparam int SSC_CTRL_CHAN_LSB = 6;
   // Play register field positions (single-cycle commands)
   localparam int SSC_PLAY_TRIG     = 0;
   localparam int SSC_PLAY_ABORT    = 1;
   // Sizes and reset values
   localparam int SSC_LEN_W         = 16;
   localparam int SSC_SEQ_W         = 10;
   localparam int SSC_EXT_W         = 8;
   localparam logic [15:0] SSC_LEN_MIN   = 16'h0003;
   localparam logic [15:0] SSC_LEN_MAX   = 16'hC000;
   localparam logic [9:0]  SSC_SEQ_MIN   = 10'h001;
   localparam logic [9:0]  SSC_SEQ_MAX   = 10'h3E8;
   localparam logic [15:0] SSC_LEN_RST   = 16'h0003;
   localparam logic [9:0]  SSC_SEQ_RST   = 10'h001;
   localparam logic [15:0] SSC_STEP_FIRST = 16'h0001;
   // Playback states
   typedef enum logic [3:0] {
      SSC_S_IDLE   = 4'b0001,
      SSC_S_LEADIN = 4'b0010,
      SSC_S_PLAY   = 4'b0100,
      SSC_S_HOLD   = 4'b1000
   } ssc_state_t;
endpackage

// >>> design/ssc_ext_select.sv
// External parallel select port synchroniser and capture
`timescale 1ns/10ps
module ssc_ext_select
   import ssc_pkg::*;
#(
   parameter int CODE_W = SSC_EXT_W
)
(
   input  wire logic              clk_sys,
   input  wire logic              arst_n,
   input  wire logic [CODE_W-1:0] code_pin,
   input  wire logic              valid_pin,
   output logic      [CODE_W-1:0] code_r,
   output logic                   take_r
);
   logic [CODE_W-1:0] code_s1_r;
   logic [CODE_W-1:0] code_s2_r;
   logic              valid_s1_r;
   logic              valid_s2_r;
   logic              valid_d_r;

   // Two-stage synchroniser on all pins
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         code_s1_r  <= '0;
         code_s2_r  <= '0;
         valid_s1_r <= 1'b0;
         valid_s2_r <= 1'b0;
      end
      else
      begin
         code_s1_r  <= code_pin;
         code_s2_r  <= code_s1_r;
         valid_s1_r <= valid_pin;
         valid_s2_r <= valid_s1_r;
      end
   end

   // Capture the code once on the rising edge of validation
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         valid_d_r <= 1'b0;
         take_r    <= 1'b0;
         code_r    <= '0;
      end
      else
      begin
         valid_d_r <= valid_s2_r;
         take_r    <= valid_s2_r && !valid_d_r;
         if (valid_s2_r && !valid_d_r)
            code_r <= code_s2_r;
      end
   end
endmodule

// >>> design/ssc_top.sv
// Sequence select controller: table lengths, selection, transition timing
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/10ps
module ssc_top
   import ssc_pkg::*;
#(
   parameter int NUM_SEQ = 1000,
   parameter int NUM_CH  = 4
)
(
   input  wire logic                 clk_sys,
   input  wire logic                 arst_n,
   input  wire logic [3:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [31:0]          reg_rdata,
   input  wire logic [SSC_EXT_W-1:0] ext_code,
   input  wire logic                 ext_valid,
   input  wire logic                 seq_end,
   output logic      [SSC_SEQ_W-1:0] play_seq_r,
   output logic      [SSC_SEQ_W-1:0] pair_a_seq_r,
   output logic      [SSC_SEQ_W-1:0] pair_b_seq_r,
   output logic      [SSC_LEN_W-1:0] play_step_r,
   output logic                      dc_out_r,
   output logic                      restart_r,
   output logic      [SSC_SEQ_W-1:0] sync_seq_r
);
   logic [SSC_LEN_W-1:0] len_mem [1:NUM_SEQ];
   logic [NUM_SEQ:1]     len_set_r;
   logic [31:0]          ctrl_r;
   logic [SSC_SEQ_W-1:0] sel_r;
   logic [SSC_SEQ_W-1:0] pend_r;
   logic                 pend_v_r;
   logic [SSC_SEQ_W-1:0] pend_b_r;
   logic [SSC_EXT_W-1:0] ext_code_r;
   logic                 ext_take_r;
   ssc_state_t           state_r;
   logic                 src_ext;
   logic                 immed;
   logic                 leadin_ok;
   logic                 trig;
   logic                 abort;
   logic                 new_sel;
   logic [SSC_SEQ_W-1:0] new_seq;
   logic [SSC_SEQ_W-1:0] new_b;
   logic                 go_now;
   logic [SSC_LEN_W-1:0] act_len;
   logic [SSC_LEN_W-1:0] wr_len;
   logic [SSC_LEN_W-1:0] play_len;

   // Clamp a sequence number into 1..1000
   function automatic logic [SSC_SEQ_W-1:0] seq_clamp(input logic [31:0] v);
      if (v[15:0] < 16'(SSC_SEQ_MIN) || v[31:16] != 16'h0000)
         seq_clamp = (v[31:16] != 16'h0000) ? SSC_SEQ_MAX : SSC_SEQ_MIN;
      else if (v[15:0] > 16'(SSC_SEQ_MAX))
         seq_clamp = SSC_SEQ_MAX;
      else
         seq_clamp = v[SSC_SEQ_W-1:0];
   endfunction

   // Clamp a table length into 3..49152
   function automatic logic [SSC_LEN_W-1:0] len_clamp(input logic [31:0] v);
      if (v[31:16] != 16'h0000 || v[15:0] > SSC_LEN_MAX)
         len_clamp = SSC_LEN_MAX;
      else if (v[15:0] < SSC_LEN_MIN)
         len_clamp = SSC_LEN_MIN;
      else
         len_clamp = v[15:0];
   endfunction

   // Length of a table; the reset length until it is first written
   function automatic logic [SSC_LEN_W-1:0] len_eff(
      input logic                 is_set,
      input logic [SSC_LEN_W-1:0] len);
      len_eff = is_set ? len : SSC_LEN_RST;
   endfunction

   ssc_ext_select #(
      .CODE_W (SSC_EXT_W)
   ) u_ext (
      .clk_sys   (clk_sys),
      .arst_n    (arst_n),
      .code_pin  (ext_code),
      .valid_pin (ext_valid),
      .code_r    (ext_code_r),
      .take_r    (ext_take_r)
   );

   // Control decode
   assign src_ext   = ctrl_r[SSC_CTRL_SRC_EXT];
   assign immed     = ctrl_r[SSC_CTRL_IMMED];
   assign leadin_ok = ctrl_r[SSC_CTRL_LEADIN] && ctrl_r[SSC_CTRL_ARMED]
                      && ctrl_r[SSC_CTRL_ARM_BUS];
   assign trig  = reg_wr && reg_addr == SSC_A_PLAY
                  && reg_wdata[SSC_PLAY_TRIG];
   assign abort = reg_wr && reg_addr == SSC_A_PLAY
                  && reg_wdata[SSC_PLAY_ABORT];
   assign act_len  = len_eff(len_set_r[sel_r], len_mem[sel_r]);
   assign play_len = len_eff(len_set_r[play_seq_r], len_mem[play_seq_r]);
   assign wr_len   = len_clamp(reg_wdata);

   // Selection request from the chosen source
   always_comb
   begin
      new_sel = 1'b0;
      new_seq = sel_r;
      new_b   = pair_b_seq_r;
      if (src_ext)
      begin
         new_sel = ext_take_r;
         new_seq = seq_clamp({24'h000000, ext_code_r} + 32'h1);
      end
      else if (reg_wr && reg_addr == SSC_A_SELECT)
      begin
         new_sel = 1'b1;
         new_seq = seq_clamp(reg_wdata);
      end
      else if (reg_wr && reg_addr == SSC_A_COUPLE
               && ctrl_r[SSC_CTRL_COUPLED])
      begin
         new_sel = 1'b1;
         new_seq = seq_clamp({16'h0000, reg_wdata[15:0]});
         new_b   = seq_clamp({16'h0000, reg_wdata[31:16]});
      end
   end

   // Switch at once when immediate, else wait for the end point
   assign go_now = (new_sel && immed)
                   || (pend_v_r && seq_end && !immed);

   // Control register
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         ctrl_r <= 32'h0000_0000;
      else if (reg_wr && reg_addr == SSC_A_CTRL)
         ctrl_r <= reg_wdata;
   end

   // Per-sequence length table
   always_ff @(posedge clk_sys)
   begin
      if (reg_wr && (reg_addr == SSC_A_LENGTH || reg_addr == SSC_A_BLOCK))
         len_mem[sel_r] <= wr_len;
      else if (reg_wr && reg_addr == SSC_A_STEPWR
               && reg_wdata[15:0] > act_len)
         len_mem[sel_r] <= wr_len;
   end

   // Tracks which tables have been written since reset
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         len_set_r <= '0;
      else if (reg_wr && (reg_addr == SSC_A_LENGTH
               || reg_addr == SSC_A_BLOCK
               || (reg_addr == SSC_A_STEPWR
                   && reg_wdata[15:0] > act_len)))
         len_set_r[sel_r] <= 1'b1;
   end

   // Active and pending selection
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sel_r    <= SSC_SEQ_RST;
         pend_r   <= SSC_SEQ_RST;
         pend_b_r <= SSC_SEQ_RST;
         pend_v_r <= 1'b0;
      end
      else
      begin
         if (new_sel)
         begin
            sel_r    <= new_seq;
            pend_r   <= new_seq;
            pend_b_r <= new_b;
         end
         if (new_sel && !immed)
            pend_v_r <= 1'b1;
         else if (go_now || abort)
            pend_v_r <= 1'b0;
      end
   end

   // Playing sequence, pair numbers and sync target
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         play_seq_r   <= SSC_SEQ_RST;
         pair_a_seq_r <= SSC_SEQ_RST;
         pair_b_seq_r <= SSC_SEQ_RST;
         sync_seq_r   <= SSC_SEQ_RST;
         restart_r    <= 1'b0;
      end
      else
      begin
         restart_r <= go_now;
         if (go_now)
         begin
            play_seq_r   <= immed ? new_seq : pend_r;
            pair_a_seq_r <= immed ? new_seq : pend_r;
            pair_b_seq_r <= immed ? new_b : pend_b_r;
            if (ctrl_r[SSC_CTRL_COUPLED])
               sync_seq_r <= immed ? new_seq : pend_r;
         end
      end
   end

   // Playback step and lead-in state
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r     <= SSC_S_IDLE;
         play_step_r <= SSC_STEP_FIRST;
         dc_out_r    <= 1'b0;
      end
      else if (abort)
      begin
         state_r     <= SSC_S_IDLE;
         play_step_r <= SSC_STEP_FIRST;
         dc_out_r    <= 1'b0;
      end
      else if (go_now)
      begin
         play_step_r <= SSC_STEP_FIRST;
         if (leadin_ok)
         begin
            state_r  <= SSC_S_LEADIN;
            dc_out_r <= 1'b1;
         end
         else
         begin
            state_r  <= SSC_S_HOLD;
            dc_out_r <= 1'b0;
         end
      end
      else
      begin
         unique case (state_r)
            SSC_S_IDLE:
               state_r <= SSC_S_IDLE;
            SSC_S_LEADIN:
               if (trig)
               begin
                  state_r  <= SSC_S_PLAY;
                  dc_out_r <= 1'b0;
               end
            SSC_S_HOLD:
               if (trig)
               begin
                  state_r     <= SSC_S_PLAY;
                  play_step_r <= play_step_r + 16'h0001;
               end
            SSC_S_PLAY:
               if (trig)
               begin
                  if (play_step_r >= play_len)
                     play_step_r <= SSC_STEP_FIRST;
                  else
                     play_step_r <= play_step_r + 16'h0001;
               end
         endcase
      end
   end

   // Register read, data valid one cycle after the strobe
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         reg_rdata <= 32'h0000_0000;
      else if (reg_rd)
      begin
         unique case (reg_addr)
            SSC_A_CTRL:
               reg_rdata <= ctrl_r;
            SSC_A_LENGTH:
               reg_rdata <= {16'h0000, act_len};
            SSC_A_SELECT:
               reg_rdata <= {22'h0, sel_r};
            SSC_A_COUPLE:
               reg_rdata <= {6'h0, pair_b_seq_r, 6'h0, pair_a_seq_r};
            SSC_A_STATUS:
               reg_rdata <= {play_step_r, state_r,
                             pend_v_r, dc_out_r, play_seq_r};
            default:
               reg_rdata <= 32'h0000_0000;
         endcase
      end
      else
         reg_rdata <= 32'h0000_0000;
   end
endmodule

// >>> test/ssc_top_monitor.sv
// Checker of selection timing at the controller ports
`timescale 1ns/10ps
module ssc_top_monitor
   import ssc_pkg::*;
(
   input wire logic                 clk_sys,
   input wire logic                 arst_n,
   input wire logic [3:0]           reg_addr,
   input wire logic [31:0]          reg_wdata,
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire logic [31:0]          reg_rdata,
   input wire logic                 seq_end,
   input wire logic [SSC_SEQ_W-1:0] play_seq_r,
   input wire logic [SSC_SEQ_W-1:0] pair_a_seq_r,
   input wire logic [SSC_LEN_W-1:0] play_step_r,
   input wire logic                 dc_out_r,
   input wire logic                 restart_r
);
   logic [5:0] ctl_r;
   logic       seen_r;
   logic       sel_wr;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // Mirror of the control bits
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         ctl_r <= 6'h00;
      else if (reg_wr && reg_addr == SSC_A_CTRL)
         ctl_r <= reg_wdata[5:0];
   end
   // Set once any sequence has started
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         seen_r <= 1'b0;
      else if (restart_r)
         seen_r <= 1'b1;
   end
   // Remote select write that the bus source accepts
   assign sel_wr = reg_wr && reg_addr == SSC_A_SELECT && !ctl_r[0];
   sequence s_sel_imm;
      sel_wr && ctl_r[1] && reg_wdata >= 32'h1 && reg_wdata <= 32'h3E8;
   endsequence
   sequence s_start;
      restart_r && {22'h0, play_seq_r} == $past(reg_wdata);
   endsequence
   property p_immed;
      s_sel_imm |=> s_start;
   endproperty
   a_immed: assert property (p_immed)
      else $error("immediate select did not start");
   property p_coh;
      sel_wr && !ctl_r[1] && seen_r && !seq_end |=> !restart_r;
   endproperty
   a_coh: assert property (p_coh)
      else $error("coherent select started early");
   property p_pulse;
      restart_r && !reg_wr && !seq_end |=> !restart_r;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("restart longer than one cycle");
   property p_chg;
      $changed(play_seq_r) |-> restart_r;
   endproperty
   a_chg: assert property (p_chg)
      else $error("sequence changed without restart");
   property p_first;
      restart_r |-> play_step_r == SSC_STEP_FIRST;
   endproperty
   a_first: assert property (p_first)
      else $error("new sequence not at first step");
   property p_lead;
      $rose(dc_out_r) |-> $past(ctl_r[2]) && $past(ctl_r[4])
         && $past(ctl_r[5]);
   endproperty
   a_lead: assert property (p_lead)
      else $error("lead-in outside armed bus mode");
   property p_rd;
      !reg_rd |=> reg_rdata == 32'h0;
   endproperty
   a_rd: assert property (p_rd)
      else $error("read data without read");
   property p_pair;
      pair_a_seq_r >= SSC_SEQ_MIN && pair_a_seq_r <= SSC_SEQ_MAX;
   endproperty
   a_pair: assert property (p_pair)
      else $error("pair sequence out of range");
endmodule

bind ssc_top ssc_top_monitor ssc_top_monitor_inst (
   .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .seq_end(seq_end), .play_seq_r(play_seq_r),
   .pair_a_seq_r(pair_a_seq_r), .play_step_r(play_step_r),
   .dc_out_r(dc_out_r), .restart_r(restart_r));

// >>> test/ssc_ext_model.sv
// External controller that drives the parallel select port
`timescale 1ns/10ps
module ssc_ext_model
   import ssc_pkg::*;
(
   input wire logic                 clk_sys,
   input wire logic                 go,
   input wire logic [SSC_EXT_W-1:0] code_in,
   output logic     [SSC_EXT_W-1:0] ext_code,
   output logic                     ext_valid
);
   int hold = 0;
   initial ext_code = 8'hA5;
   initial ext_valid = 1'b0;
   // Code set first, valid raised later, code kept while valid high
   always @(posedge clk_sys)
   begin
      if (go)
         hold <= 8;
      else if (hold > 0)
         hold <= hold - 1;
      if (go)
         ext_code <= code_in;
      else if (hold == 0)
         ext_code <= ~ext_code;
      ext_valid <= hold > 1 && hold < 8;
   end
endmodule

// >>> test/ssc_top_bench.sv
// Self-checking bench of the sequence select controller
`timescale 1ns/10ps
module ssc_top_bench
   import ssc_pkg::*;
;
   logic clk_sys = 0, arst_n = 0, reg_wr = 0, reg_rd = 0;
   logic seq_end = 0, go = 0, ext_valid, restart_r, dc_out_r;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [7:0] code_in = 8'h00, ext_code;
   logic [9:0] play_seq_r, pair_a_seq_r, pair_b_seq_r, sync_seq_r;
   logic [15:0] play_step_r;
   int bad_count = 0, n_tests = 0;
   always #20 clk_sys = ~clk_sys;
   ssc_top ssc_top_inst (.clk_sys(clk_sys), .arst_n(arst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_code(ext_code),
      .ext_valid(ext_valid), .seq_end(seq_end), .play_seq_r(play_seq_r),
      .pair_a_seq_r(pair_a_seq_r), .pair_b_seq_r(pair_b_seq_r),
      .play_step_r(play_step_r), .dc_out_r(dc_out_r),
      .restart_r(restart_r), .sync_seq_r(sync_seq_r));
   ssc_ext_model ssc_ext_model_inst (.clk_sys(clk_sys), .go(go),
      .code_in(code_in), .ext_code(ext_code), .ext_valid(ext_valid));
   // Report and end
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk("rdata", e, reg_rdata);
   endtask
   task automatic wait_seq(input logic [9:0] e);
      int i;
      for (i = 0; i < 40 && play_seq_r !== e; i++)
         @(posedge clk_sys);
      #1 chk("play_seq", e, play_seq_r);
      if (i == 40)
         finish_test();
   endtask
   // One-cycle pulse on the port go line or on the end point
   task automatic pulse(input logic use_go);
      @(posedge clk_sys);
      if (use_go)
         go <= 1'b1;
      else
         seq_end <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      seq_end <= 1'b0;
   endtask
   // Main sequence of register and port scenarios
   initial
   begin
      repeat (8) @(posedge clk_sys);
      arst_n <= 1'b1;
      rd(SSC_A_LENGTH, 32'h3);
      rd(SSC_A_SELECT, 32'h1);
      wr(SSC_A_LENGTH, 32'h2);
      rd(SSC_A_LENGTH, 32'h3);
      wr(SSC_A_LENGTH, 32'hC001);
      rd(SSC_A_LENGTH, 32'hC000);
      wr(SSC_A_LENGTH, 32'hA);
      wr(SSC_A_CTRL, 32'h2);
      wr(SSC_A_SELECT, 32'h5);
      #1 chk("restart", 1, restart_r);
      chk("play_seq", 5, play_seq_r);
      rd(SSC_A_LENGTH, 32'h3);
      wr(SSC_A_STEPWR, 32'h14);
      rd(SSC_A_LENGTH, 32'h14);
      wr(SSC_A_SELECT, 32'h1);
      rd(SSC_A_LENGTH, 32'hA);
      wr(SSC_A_BLOCK, 32'h7);
      rd(SSC_A_LENGTH, 32'h7);
      wr(4'hF, 32'h5);
      rd(SSC_A_LENGTH, 32'h7);
      wr(SSC_A_CTRL, 32'h0);
      wr(SSC_A_SELECT, 32'h9);
      repeat (4) @(posedge clk_sys);
      #1 chk("play_seq", 1, play_seq_r);
      pulse(1'b0);
      wait_seq(10'h9);
      wr(SSC_A_CTRL, 32'h3);
      wr(SSC_A_SELECT, 32'h14);
      rd(SSC_A_SELECT, 32'h9);
      code_in <= 8'h3;
      pulse(1'b1);
      wait_seq(10'h4);
      wr(SSC_A_CTRL, 32'h1);
      code_in <= 8'h7;
      pulse(1'b1);
      repeat (12) @(posedge clk_sys);
      #1 chk("play_seq", 4, play_seq_r);
      pulse(1'b0);
      wait_seq(10'h8);
      wr(SSC_A_CTRL, 32'hA);
      wr(SSC_A_COUPLE, 32'h000C000B);
      @(posedge clk_sys);
      #1 chk("pair_a", 11, pair_a_seq_r);
      chk("pair_b", 12, pair_b_seq_r);
      chk("sync", 11, sync_seq_r);
      wr(SSC_A_CTRL, 32'h36);
      wr(SSC_A_SELECT, 32'h6);
      @(posedge clk_sys);
      #1 chk("dc_out", 1, dc_out_r);
      rd(SSC_A_LENGTH, 32'h3);
      wr(SSC_A_PLAY, 32'h1);
      @(posedge clk_sys);
      #1 chk("dc_out", 0, dc_out_r);
      chk("step", 1, play_step_r);
      wr(SSC_A_PLAY, 32'h1);
      wr(SSC_A_PLAY, 32'h1);
      #1 chk("step", 3, play_step_r);
      wr(SSC_A_PLAY, 32'h1);
      #1 chk("step", 1, play_step_r);
      chk("dc_out", 0, dc_out_r);
      rd(SSC_A_STATUS, 32'h0001_4006);
      wr(SSC_A_PLAY, 32'h2);
      rd(SSC_A_STATUS, 32'h0001_1006);
      chk("sync", 11, sync_seq_r);
      wr(SSC_A_CTRL, 32'h6);
      wr(SSC_A_SELECT, 32'h7);
      #1 chk("step", 1, play_step_r);
      chk("dc_out", 0, dc_out_r);
      wr(SSC_A_PLAY, 32'h1);
      #1 chk("step", 2, play_step_r);
      finish_test();
   end
endmodule
